// [trig_ctrl_regs.vh]
// Purpose: register map and constants of the measurement trigger controller
// Assumes: AHB-Lite, 32-bit words, 20 MHz hclk
// Notes:   all offsets are byte addresses
`ifndef TRIG_CTRL_REGS_VH
`define TRIG_CTRL_REGS_VH

`define OFS_CTRL        12'h000
`define OFS_CMD         12'h004
`define OFS_SOURCE      12'h008
`define OFS_TRIG_COUNT  12'h00c
`define OFS_SAMP_COUNT  12'h010
`define OFS_DELAY       12'h014
`define OFS_STATUS      12'h018
`define OFS_LIMITS      12'h01c
`define OFS_PROGRESS    12'h020

// command bits
`define CMD_CONFIGURE   0
`define CMD_MEASURE     1
`define CMD_INITIATE    2
`define CMD_BUS_TRIG    3
`define CMD_ERR_CLR     4
`define CMD_ABORT       5

// source codes: 0..7 backplane line, then bus, external, immediate
`define SRC_BUS         4'h8
`define SRC_EXT         4'h9
`define SRC_IMM         4'ha

// status bits
`define STS_WAIT        0
`define STS_BUSY        1
`define STS_CONFLICT    2
`define STS_SETUP       3
`define STS_BUS_REJ     4

`define CNT_MIN         16'h0001
`define CNT_MAX         16'hc350
`define DELAY_MAX       32'hd693a400
`define SETUP_MS        20
`define CLK_MHZ         20
`define SETUP_CYC       (`SETUP_MS * 1000 * `CLK_MHZ)
`define US_CYC          `CLK_MHZ

`endif

// [fall_edge_sync.v]
// Purpose: synchronise an async input and flag its falling edges
// Assumes: input comes from a pin outside hclk's domain
// Notes:   stage one feeds stage two only
`timescale 1ns/1ns
module fall_edge_sync
(
  input  wire hclk,
  input  wire hresetn,
  input  wire pin_in,
  output wire fall_pulse
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign fall_pulse = s3_ff & ~s2_ff;

endmodule

// [measurement_trigger_control.v]
// Purpose: trigger controller for a measurement module, AHB-Lite slave
// Assumes: single 32-bit transfers, one wait-free data phase
// Notes:   readings are requested by a one-cycle reading_start pulse
//
// Summary of operation
// - always idle or waiting for trigger
// - source: bus, external, immediate, backplane 0-7
// - external falling edge is a trigger
// - chosen backplane line falling edge triggers
// - immediate source triggers at once
// - configure or measure selects immediate source
// - source change in wait flags settings conflict
// - source readback gives selection code
// - each trigger takes configured reading count
// - measure uses immediate source, one reading
// - bus trigger only when bus source, waiting
// - group trigger needs bus source, last listener
// - triggers in idle are discarded
// - triggers ignored 20 ms after entering wait
// - return to idle after trigger count
// - min keyword 1, max keyword 50000
// - configure or measure set trigger count one
// - count readback, limits readable too
// - delay precedes every reading of a trigger
// - delay 0 to 3600 s, 1 us step
// - readings per trigger 1 to 50000
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`include "trig_ctrl_regs.vh"
module measurement_trigger_control
#(
  parameter SETUP_CYCLES = `SETUP_CYC
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        ext_trig_n,
  input  wire [7:0]  ttl_trig_n,
  input  wire        group_exec_trig,
  input  wire        last_listener,
  input  wire        reading_done,
  output reg         reading_start,
  output reg         wait_state,
  output reg         settings_conflict
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_SETUP = 5'h02;
  localparam [4:0] ST_ARMED = 5'h04;
  localparam [4:0] ST_DELAY = 5'h08;
  localparam [4:0] ST_READ  = 5'h10;

  reg  [4:0]  state_ff;
  reg  [4:0]  nxt_state;
  reg  [3:0]  source_ff;
  reg  [15:0] trig_count_ff;
  reg  [15:0] samp_count_ff;
  reg  [31:0] delay_us_ff;
  reg         bus_rej_ff;
  reg  [31:0] cyc_ff;
  reg  [31:0] nxt_cyc;
  reg  [4:0]  us_ff;
  reg  [15:0] trig_done_ff;
  reg  [15:0] samp_done_ff;
  reg  [15:0] nxt_trig_done;
  reg  [15:0] nxt_samp_done;
  reg         meas_one_ff;
  reg         wr_pend_ff;
  reg  [11:0] wr_addr_ff;
  reg         nxt_start;

  wire        ext_fall;
  wire [7:0]  ttl_fall;
  wire        wr_req;
  wire        wr_now;
  wire        waiting;
  wire [31:0] wd;
  wire        cmd_cfg;
  wire        cmd_meas;
  wire        cmd_init;
  wire        cmd_bus;
  wire        cmd_abort;
  wire        src_wr;
  wire        bus_ok;
  wire        gexec_ok;
  wire        trig_hit;
  wire        us_tick;
  wire [15:0] tc_wr;
  wire [15:0] sc_wr;

  fall_edge_sync u_ext_sync
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_in     (ext_trig_n),
    .fall_pulse (ext_fall)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_ttl
      fall_edge_sync u_ttl_sync
      (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (ttl_trig_n[g]),
        .fall_pulse (ttl_fall[g])
      );
    end
  endgenerate

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_req    = hsel & hready & htrans[1] & hwrite;
  assign wr_now    = wr_pend_ff;
  assign wd        = hwdata;
  assign waiting   = (state_ff != ST_IDLE);

  assign cmd_cfg   = wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_CONFIGURE] && !waiting;
  assign cmd_meas  = wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_MEASURE] && !waiting;
  assign cmd_init  = wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_INITIATE] && !waiting;
  assign cmd_bus   = wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_BUS_TRIG];
  assign cmd_abort = wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_ABORT];
  assign src_wr    = wr_now && (wr_addr_ff == `OFS_SOURCE);

  // min/max keywords carried as write bits 31 and 30
  assign tc_wr = wd[31] ? `CNT_MIN : wd[30] ? `CNT_MAX :
                 (wd[15:0] == 16'h0000) ? `CNT_MIN : (wd[15:0] > `CNT_MAX) ? `CNT_MAX : wd[15:0];
  assign sc_wr = wd[31] ? `CNT_MIN : wd[30] ? `CNT_MAX :
                 (wd[15:0] == 16'h0000) ? `CNT_MIN : (wd[15:0] > `CNT_MAX) ? `CNT_MAX : wd[15:0];

  assign bus_ok   = cmd_bus && (source_ff == `SRC_BUS) && (state_ff == ST_ARMED);
  assign gexec_ok = group_exec_trig && last_listener && (source_ff == `SRC_BUS)
                    && (state_ff == ST_ARMED);

  // only the armed state honours triggers
  assign trig_hit = (state_ff == ST_ARMED) &&
                    ((source_ff == `SRC_IMM) ||
                     ((source_ff == `SRC_EXT) && ext_fall) ||
                     (!source_ff[3] && ttl_fall[source_ff[2:0]]) ||
                     bus_ok || gexec_ok);

  assign us_tick = ({27'h0, us_ff} == `US_CYC - 1);

  // bus write address phase capture
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end
    else
    begin
      wr_pend_ff <= wr_req;
      wr_addr_ff <= haddr[11:0];
    end
  end

  // configuration registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      source_ff     <= `SRC_IMM;
      trig_count_ff <= `CNT_MIN;
      samp_count_ff <= `CNT_MIN;
      delay_us_ff   <= 32'h00000000;
      meas_one_ff   <= 1'b0;
    end
    else
    begin
      if (cmd_cfg || cmd_meas)
      begin
        source_ff     <= `SRC_IMM;
        trig_count_ff <= `CNT_MIN;
      end
      else if (src_wr && !waiting && (wd[3:0] <= `SRC_IMM))
        source_ff <= wd[3:0];
      if (wr_now && (wr_addr_ff == `OFS_TRIG_COUNT) && !waiting)
        trig_count_ff <= tc_wr;
      if (wr_now && (wr_addr_ff == `OFS_SAMP_COUNT) && !waiting)
        samp_count_ff <= sc_wr;
      if (wr_now && (wr_addr_ff == `OFS_DELAY) && !waiting)
        delay_us_ff <= wd[31] ? 32'h00000000 : wd[30] ? `DELAY_MAX :
                       (wd > `DELAY_MAX) ? `DELAY_MAX : wd;
      if (cmd_meas)
        meas_one_ff <= 1'b1;
      else if (state_ff == ST_IDLE && nxt_state == ST_IDLE)
        meas_one_ff <= meas_one_ff & ~cmd_init;
      if ((state_ff != ST_IDLE) && (nxt_state == ST_IDLE))
        meas_one_ff <= 1'b0;
    end
  end

  // error flags: set wins over clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settings_conflict <= 1'b0;
      bus_rej_ff        <= 1'b0;
    end
    else
    begin
      if (src_wr && waiting)
        settings_conflict <= 1'b1;
      else if (wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_ERR_CLR])
        settings_conflict <= 1'b0;
      if (cmd_bus && !bus_ok)
        bus_rej_ff <= 1'b1;
      else if (wr_now && (wr_addr_ff == `OFS_CMD) && wd[`CMD_ERR_CLR])
        bus_rej_ff <= 1'b0;
    end
  end

  // microsecond prescaler, restarted with each delay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      us_ff <= 5'h00;
    else if (state_ff != ST_DELAY || us_tick)
      us_ff <= 5'h00;
    else
      us_ff <= us_ff + 5'd1;
  end

  // trigger state machine
  always @*
  begin
    nxt_state     = state_ff;
    nxt_cyc       = cyc_ff;
    nxt_trig_done = trig_done_ff;
    nxt_samp_done = samp_done_ff;
    nxt_start     = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (cmd_init || cmd_meas)
        begin
          nxt_state     = ST_SETUP;
          nxt_cyc       = 32'h00000000;
          nxt_trig_done = 16'h0000;
        end
      end
      ST_SETUP:
      begin
        if (cyc_ff >= SETUP_CYCLES - 1)
          nxt_state = ST_ARMED;
        else
          nxt_cyc = cyc_ff + 32'h00000001;
      end
      ST_ARMED:
      begin
        if (trig_hit)
        begin
          nxt_state     = ST_DELAY;
          nxt_cyc       = 32'h00000000;
          nxt_samp_done = 16'h0000;
        end
      end
      ST_DELAY:
      begin
        if (cyc_ff >= delay_us_ff)
        begin
          nxt_state = ST_READ;
          nxt_start = 1'b1;
        end
        else if (us_tick)
          nxt_cyc = cyc_ff + 32'h00000001;
      end
      ST_READ:
      begin
        if (reading_done)
        begin
          nxt_samp_done = samp_done_ff + 16'h0001;
          nxt_cyc       = 32'h00000000;
          if (meas_one_ff || (samp_done_ff + 16'h0001 >= samp_count_ff))
          begin
            nxt_trig_done = trig_done_ff + 16'h0001;
            if (meas_one_ff || (trig_done_ff + 16'h0001 >= trig_count_ff))
              nxt_state = ST_IDLE;
            else
              nxt_state = ST_ARMED;
          end
          else
            nxt_state = ST_DELAY;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (cmd_abort)
      nxt_state = ST_IDLE;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff      <= ST_IDLE;
      cyc_ff        <= 32'h00000000;
      trig_done_ff  <= 16'h0000;
      samp_done_ff  <= 16'h0000;
      reading_start <= 1'b0;
      wait_state    <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      cyc_ff        <= nxt_cyc;
      trig_done_ff  <= nxt_trig_done;
      samp_done_ff  <= nxt_samp_done;
      reading_start <= nxt_start;
      wait_state    <= (nxt_state != ST_IDLE);
    end
  end

  // read data, registered at the address phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hsel && hready && htrans[1] && !hwrite)
    begin
      if (haddr[11:0] == `OFS_CTRL)
        hrdata <= {27'h0000000, state_ff};
      else if (haddr[11:0] == `OFS_SOURCE)
        hrdata <= {28'h0000000, source_ff};
      else if (haddr[11:0] == `OFS_TRIG_COUNT)
        hrdata <= {16'h0000, trig_count_ff};
      else if (haddr[11:0] == `OFS_SAMP_COUNT)
        hrdata <= {16'h0000, samp_count_ff};
      else if (haddr[11:0] == `OFS_DELAY)
        hrdata <= delay_us_ff;
      else if (haddr[11:0] == `OFS_STATUS)
        hrdata <= {27'h0000000, bus_rej_ff, (state_ff == ST_SETUP), settings_conflict,
                   (state_ff == ST_DELAY || state_ff == ST_READ), waiting};
      else if (haddr[11:0] == `OFS_LIMITS)
        hrdata <= {`CNT_MAX, `CNT_MIN};
      else if (haddr[11:0] == `OFS_PROGRESS)
        hrdata <= {samp_done_ff, trig_done_ff};
      else
        hrdata <= 32'h00000000;
    end
  end

endmodule

// [trig_ctrl_checker_asserts.sv]
// Purpose: port checker for the trigger controller
// Assumes: one clock, reset hresetn
// Notes:   bound from the bench top file
`timescale 1ns/1ns
module trig_ctrl_checker
#(
  parameter SETUP_CYCLES = 8
)
(
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hreadyout,
  input wire       hresp,
  input wire       reading_done,
  input wire       reading_start,
  input wire       wait_state,
  input wire       settings_conflict
);
  reg       busy_ff;
  reg [19:0] cnt_ff;
  // reading in flight, cycles since wait began
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      busy_ff <= 1'b0;
    else
      busy_ff <= reading_start | (busy_ff & ~reading_done);
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_ff <= 20'h00000;
    else if (!wait_state)
      cnt_ff <= 20'h00000;
    else if (cnt_ff != 20'hfffff)
      cnt_ff <= cnt_ff + 20'h00001;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_start_wait; reading_start |-> wait_state; endproperty
  a_start_wait: assert property (p_start_wait)
    else $error("reading started while idle");
  property p_start_pulse; reading_start |=> !reading_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  property p_setup; reading_start |-> cnt_ff >= SETUP_CYCLES; endproperty
  a_setup: assert property (p_setup)
    else $error("reading inside setup time");
  property p_one_reading; reading_start |-> !busy_ff; endproperty
  a_one_reading: assert property (p_one_reading)
    else $error("reading started before previous done");
  property p_wait_cause;
    $rose(wait_state) |-> $past(hsel, 2) && $past(hwrite, 2) && $past(htrans[1], 2);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait entered without a write");
  property p_conflict_set; $rose(settings_conflict) |-> $past(wait_state); endproperty
  a_conflict_set: assert property (p_conflict_set)
    else $error("conflict raised while idle");
  property p_conflict_clr; $fell(settings_conflict) |-> $past(hwrite, 2); endproperty
  a_conflict_clr: assert property (p_conflict_clr)
    else $error("conflict dropped without a write");
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready okay");
endmodule

// [reading_responder.sv]
// Purpose: measurement datapath stand-in
// Assumes: one reading per start pulse
// Notes:   answers done a fixed latency later
`timescale 1ns/1ns
module reading_responder
#(
  parameter [3:0] LAT = 4'h3
)
(
  input  wire hclk,
  input  wire hresetn,
  input  wire reading_start,
  output wire reading_done
);
  reg [3:0] cnt_ff;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_ff <= 4'h0;
    else if (reading_start)
      cnt_ff <= LAT;
    else if (cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
  assign reading_done = (cnt_ff == 4'h1);
endmodule

// [measurement_trigger_control_tb.sv]
// Purpose: self-checking bench for the trigger controller
// Assumes: zero-wait slave, setup count cut to 8
// Notes:   readings answered by reading_responder
`timescale 1ns/1ns
`include "trig_ctrl_regs.vh"
module measurement_trigger_control_tb;
  reg         hclk, hresetn, hsel, hwrite, ext_n, gtrig, lstn;
  reg  [31:0] haddr, hwdata, q;
  reg  [1:0]  htrans;
  reg  [7:0]  ttl_n;
  wire [31:0] hrdata;
  wire        rdy, hresp, done, start, wait_st, conf;
  integer     bad_count, check_count, starts, s0, i;
  measurement_trigger_control #(.SETUP_CYCLES(8)) measurement_trigger_control_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata), .ext_trig_n(ext_n),
    .ttl_trig_n(ttl_n), .group_exec_trig(gtrig), .last_listener(lstn), .reading_done(done),
    .reading_start(start), .wait_state(wait_st), .settings_conflict(conf));
  reading_responder reading_responder_inst (.hclk(hclk), .hresetn(hresetn), .reading_start(start),
    .reading_done(done));
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (start === 1'b1)
      starts <= starts + 1;
  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    q = hrdata;
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input [11:0] a, input [31:0] e);
  begin
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  end
  endtask
  task idle;
  begin
    repeat (2) @(posedge hclk);
    for (i = 0; i < 3000 && wait_st !== 1'b0; i = i + 1) @(posedge hclk);
    chk({31'h0, wait_st}, 32'h0);
  end
  endtask
  task pls(input [8:0] m);
  begin
    {ttl_n, ext_n} <= ~m;
    repeat (4) @(posedge hclk);
    {ttl_n, ext_n} <= 9'h1ff;
    repeat (60) @(posedge hclk);
  end
  endtask
  task gp(input l);
  begin
    lstn <= l;
    gtrig <= 1'b1;
    @(posedge hclk);
    gtrig <= 1'b0;
    repeat (60) @(posedge hclk);
  end
  endtask
  task t_regs;
  begin
    rdc(`OFS_SOURCE, 32'ha);
    rdc(`OFS_TRIG_COUNT, 32'h1);
    rdc(`OFS_SAMP_COUNT, 32'h1);
    rdc(`OFS_DELAY, 32'h0);
    rdc(`OFS_LIMITS, 32'hc3500001);
    rdc(`OFS_CTRL, 32'h1);
    rdc(12'h030, 32'h0);
    for (s0 = 0; s0 < 11; s0 = s0 + 1)
    begin
      wr(`OFS_SOURCE, s0);
      rdc(`OFS_SOURCE, s0);
    end
    wr(`OFS_SOURCE, 32'h9);
    wr(`OFS_SOURCE, 32'hb);
    rdc(`OFS_SOURCE, 32'h9);
    $display("test regs done");
  end
  endtask
  task t_limits;
  begin
    wr(`OFS_TRIG_COUNT, 32'h40000000);
    rdc(`OFS_TRIG_COUNT, 32'hc350);
    wr(`OFS_TRIG_COUNT, 32'h80000000);
    rdc(`OFS_TRIG_COUNT, 32'h1);
    wr(`OFS_TRIG_COUNT, 32'hc351);
    rdc(`OFS_TRIG_COUNT, 32'hc350);
    wr(`OFS_SAMP_COUNT, 32'h40000000);
    rdc(`OFS_SAMP_COUNT, 32'hc350);
    wr(`OFS_DELAY, 32'h40000000);
    rdc(`OFS_DELAY, 32'hd693a400);
    wr(`OFS_CMD, 32'h1);
    rdc(`OFS_TRIG_COUNT, 32'h1);
    rdc(`OFS_SOURCE, 32'ha);
    $display("test limits done");
  end
  endtask
  task t_imm;
  begin
    wr(`OFS_SAMP_COUNT, 32'h2);
    wr(`OFS_DELAY, 32'h1);
    s0 = starts;
    wr(`OFS_CMD, 32'h4);
    idle;
    chk(starts - s0, 32'h2);
    rdc(`OFS_PROGRESS, 32'h00020001);
    wr(`OFS_SOURCE, 32'h9);
    wr(`OFS_TRIG_COUNT, 32'h3);
    s0 = starts;
    wr(`OFS_CMD, 32'h2);
    idle;
    chk(starts - s0, 32'h1);
    rdc(`OFS_SOURCE, 32'ha);
    rdc(`OFS_TRIG_COUNT, 32'h1);
    $display("test immediate done");
  end
  endtask
  task t_ext;
  begin
    wr(`OFS_SAMP_COUNT, 32'h1);
    wr(`OFS_DELAY, 32'h0);
    wr(`OFS_SOURCE, 32'h9);
    wr(`OFS_TRIG_COUNT, 32'h2);
    s0 = starts;
    pls(9'h001);
    chk(starts - s0, 32'h0);
    wr(`OFS_CMD, 32'h4);
    pls(9'h001);
    chk(starts - s0, 32'h0);
    pls(9'h001);
    pls(9'h002);
    chk(starts - s0, 32'h1);
    pls(9'h001);
    idle;
    chk(starts - s0, 32'h2);
    wr(`OFS_SOURCE, 32'h5);
    wr(`OFS_TRIG_COUNT, 32'h1);
    wr(`OFS_CMD, 32'h4);
    repeat (20) @(posedge hclk);
    pls(9'h021);
    chk(starts - s0, 32'h2);
    pls(9'h040);
    idle;
    chk(starts - s0, 32'h3);
    $display("test external done");
  end
  endtask
  task t_bus;
  begin
    wr(`OFS_SOURCE, 32'h8);
    wr(`OFS_CMD, 32'h8);
    rdc(`OFS_STATUS, 32'h10);
    wr(`OFS_CMD, 32'h10);
    rdc(`OFS_STATUS, 32'h0);
    wr(`OFS_TRIG_COUNT, 32'h2);
    s0 = starts;
    wr(`OFS_CMD, 32'h4);
    repeat (20) @(posedge hclk);
    wr(`OFS_CMD, 32'h8);
    gp(1'b0);
    chk(starts - s0, 32'h1);
    gp(1'b1);
    idle;
    chk(starts - s0, 32'h2);
    $display("test bus done");
  end
  endtask
  task t_conflict;
  begin
    wr(`OFS_SOURCE, 32'h9);
    wr(`OFS_TRIG_COUNT, 32'h1);
    wr(`OFS_CMD, 32'h4);
    rdc(`OFS_STATUS, 32'h9);
    repeat (20) @(posedge hclk);
    wr(`OFS_SOURCE, 32'h2);
    @(posedge hclk);
    chk({31'h0, conf}, 32'h1);
    rdc(`OFS_STATUS, 32'h5);
    rdc(`OFS_SOURCE, 32'h9);
    wr(`OFS_CMD, 32'h30);
    @(posedge hclk);
    chk({30'h0, conf, wait_st}, 32'h0);
    $display("test conflict done");
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    {hclk, hresetn, hsel, hwrite, gtrig, lstn} = 6'h0;
    {ext_n, ttl_n} = 9'h1ff;
    {haddr, hwdata, q} = 96'h0;
    htrans = 2'h0;
    {bad_count, check_count, starts} = 96'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_limits;
    t_imm;
    t_ext;
    t_bus;
    t_conflict;
    end_of_test;
  end
  initial
  begin
    #3000000;
    bad_count = bad_count + 1;
    end_of_test;
  end
endmodule
bind measurement_trigger_control trig_ctrl_checker #(.SETUP_CYCLES(SETUP_CYCLES)) trig_ctrl_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .reading_done(reading_done), .reading_start(reading_start), .wait_state(wait_state),
  .settings_conflict(settings_conflict));
